// ==== src/csoc_map.vh ====
`ifndef CSOC_MAP_VH
`define CSOC_MAP_VH

// ---------------------------------------------------------------------
// Register offsets (9-bit register address space)
// ---------------------------------------------------------------------
`define CSOC_ADDR_W         9
`define CSOC_ADDR_DRAIN7    9'h182
`define CSOC_ADDR_DRAIN8    9'h183
`define CSOC_ADDR_OFSDIV    9'h1a4

// ---------------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------------
`define CSOC_DRAIN_FAST_BIT 0
`define CSOC_DRAIN_REG_BIT  1
`define CSOC_DRAIN_RST      16'h0000

// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define CSOC_REF_CLK_KHZ    50000
`define CSOC_OFS_CLK_MAX_KHZ 500
`define CSOC_OFS_DIV_MIN    (`CSOC_REF_CLK_KHZ / `CSOC_OFS_CLK_MAX_KHZ)
`define CSOC_OFSDIV_RST     16'h0063
`define CSOC_OFS_STEPS      5'h1f

`endif

// ==== src/csoc_ofs_seq.v ====
`timescale 1ns/1ps
`include "csoc_map.vh"

// Automatic offset compensation sequencer shared by all six channels.
module csoc_ofs_seq (
  // Clock and reset.
  input  wire        clk,
  input  wire        rst_n,
  // Prescaled compensation step enable.
  input  wire        step_en,
  // Start and stop commands with target channel.
  input  wire        start,
  input  wire        stop,
  input  wire [2:0]  chan,
  // Synchronised comparator feedback, one bit per channel.
  input  wire [5:0]  cmp,
  // Correction words, sign and magnitude, six bits per channel.
  output reg  [35:0] corr,
  output reg  [5:0]  active,
  output reg         busy
);

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  reg signed [5:0] mem_reg [0:5];  // Correction kept per channel.
  reg [2:0]        ch_reg;         // Channel under compensation.
  reg [4:0]        steps_reg;      // Steps taken in this run.
  reg              dir_reg;        // Direction of the previous step.
  reg              first_reg;      // No step taken yet.
  integer          i;              // Loop index of the sequencer.
  integer          j;              // Loop index of the output view.

  // Signed value to sign and magnitude for the analog correction DAC.
  function [5:0] to_sm;
    input signed [5:0] v;
    begin
      if (v < 0) begin
        to_sm = {1'b1, 5'h00 - v[4:0]};
      end else begin
        to_sm = {1'b0, v[4:0]};
      end
    end
  endfunction

  // -------------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------------
  // Each step moves the correction one code against the comparator, up to +/-31;
  // the run ends at the first reversal or after the step budget. The
  // stored word is cleared only by reset, so a new run resumes from it and an
  // aborted run keeps what it reached.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 6; i = i + 1) begin
        mem_reg[i] <= 6'sd0;
      end
      ch_reg    <= 3'h0;
      steps_reg <= 5'h00;
      dir_reg   <= 1'b0;
      first_reg <= 1'b0;
      busy      <= 1'b0;
    end else if (busy) begin
      if (stop) begin
        busy <= 1'b0;
      end else if (step_en) begin
        if ((!first_reg && dir_reg != cmp[ch_reg]) ||
            steps_reg == `CSOC_OFS_STEPS) begin
          busy <= 1'b0;
        end else begin
          first_reg <= 1'b0;
          dir_reg   <= cmp[ch_reg];
          steps_reg <= steps_reg + 5'h01;
          // Comparator high means the offset is positive: step down.
          if (cmp[ch_reg] && mem_reg[ch_reg] != -6'sd31) begin
            mem_reg[ch_reg] <= mem_reg[ch_reg] - 6'sd1;
          end else if (!cmp[ch_reg] && mem_reg[ch_reg] != 6'sd31) begin
            mem_reg[ch_reg] <= mem_reg[ch_reg] + 6'sd1;
          end
        end
      end
    end else if (start && chan < 3'h6) begin
      ch_reg    <= chan;
      steps_reg <= 5'h00;
      first_reg <= 1'b1;
      busy      <= 1'b1;
    end
  end

  // Registered view of the correction words and the active channel.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      corr   <= 36'h0;
      active <= 6'h00;
    end else begin
      for (j = 0; j < 6; j = j + 1) begin
        corr[j*6 +: 6] <= to_sm(mem_reg[j]);
        active[j]      <= busy && (ch_reg == j[2:0]);
      end
    end
  end

endmodule

// ==== src/csoc_top.v ====
`timescale 1ns/1ps
`include "csoc_map.vh"

module csoc_top (
  // Clock and reset.
  input  wire        REF_CLK,
  input  wire        RESETN,
  // Register port.
  input  wire        REG_WR,
  input  wire        REG_RD,
  input  wire [8:0]  REG_ADDR,
  input  wire [15:0] REG_WDATA,
  output reg  [15:0] REG_RDATA,
  // Microcore gain command.
  input  wire        GAIN_WE,
  input  wire [2:0]  GAIN_CH,
  input  wire [1:0]  GAIN_VAL,
  // Microcore threshold command; channels 6 and 7 are high DACs.
  input  wire        DAC_WE,
  input  wire [2:0]  DAC_CH,
  input  wire [7:0]  DAC_VAL,
  // Microcore negative threshold command.
  input  wire        NEG_WE,
  input  wire        NEG_CH,
  input  wire [3:0]  NEG_VAL,
  // Microcore compensation command.
  input  wire        OFS_START,
  input  wire        OFS_STOP,
  input  wire [2:0]  OFS_CH,
  // Microcore ADC conversion request per channel.
  input  wire [5:0]  ADC_CONV,
  // Analog comparator feedback.
  input  wire [3:0]  CUR_FBK,
  input  wire [1:0]  HIGH_FBK,
  input  wire [1:0]  LOW_FBK,
  input  wire [1:0]  NEG_FBK,
  input  wire [1:0]  DRAIN_FBK,
  input  wire [1:0]  DRAIN_FAST_FBK,
  // Analog controls.
  output reg  [11:0] GAIN_SEL,
  output reg  [47:0] DAC_CODE,
  output reg  [15:0] DAC_HIGH_CODE,
  output reg  [7:0]  NEG_CODE,
  output reg  [5:0]  TRACK_HOLD,
  output wire [35:0] OFS_CORR,
  output wire [5:0]  OFS_ACTIVE,
  output wire        OFS_BUSY,
  output reg  [1:0]  DRAIN_FAST_EN,
  // Digital results.
  output reg  [1:0]  DRAIN_DIAG,
  output reg  [1:0]  RESONANCE,
  output reg  [1:0]  DCDC_GATE,
  output reg  [1:0]  BOOST_OVC
);

  // -------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------
  reg  [15:0] drain7_reg;   // Drain monitor 7 configuration.
  reg  [15:0] drain8_reg;   // Drain monitor 8 configuration.
  reg  [15:0] ofsdiv_reg;   // Compensation clock divider.
  reg  [15:0] div_cnt_reg;  // Divider counter.
  reg         step_en;      // One-cycle compensation clock enable.
  reg  [11:0] sync1_reg;    // First synchroniser stage.
  reg  [11:0] sync2_reg;    // Second synchroniser stage.
  integer     i;            // Loop index of the command process.
  integer     j;            // Loop index of the regulation process.

  // Synchronised feedback fields.
  wire [3:0] cur_s   = sync2_reg[3:0];
  wire [1:0] high_s  = sync2_reg[5:4];
  wire [1:0] low_s   = sync2_reg[7:6];
  wire [1:0] neg_s   = sync2_reg[9:8];
  wire [1:0] drn_s   = sync2_reg[11:10];
  wire [1:0] fast_s;
  reg  [1:0] fast1_reg;
  reg  [1:0] fast2_reg;
  assign fast_s = fast2_reg;

  // Mode bits of both converter drains.
  wire [1:0] fast_mode = {drain8_reg[`CSOC_DRAIN_FAST_BIT],
                          drain7_reg[`CSOC_DRAIN_FAST_BIT]};
  wire [1:0] reg_mode  = {drain8_reg[`CSOC_DRAIN_REG_BIT],
                          drain7_reg[`CSOC_DRAIN_REG_BIT]};

  // -------------------------------------------------------------------
  // Register port
  // -------------------------------------------------------------------
  // Writes take effect on the next edge; unmapped reads return zero.
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      drain7_reg <= `CSOC_DRAIN_RST;
      drain8_reg <= `CSOC_DRAIN_RST;
      ofsdiv_reg <= `CSOC_OFSDIV_RST;
      REG_RDATA  <= 16'h0000;
    end else begin
      if (REG_WR) begin
        case (REG_ADDR)
          `CSOC_ADDR_DRAIN7: drain7_reg <= REG_WDATA;
          `CSOC_ADDR_DRAIN8: drain8_reg <= REG_WDATA;
          `CSOC_ADDR_OFSDIV: ofsdiv_reg <= REG_WDATA;
          default: ;
        endcase
      end
      if (REG_RD) begin
        case (REG_ADDR)
          `CSOC_ADDR_DRAIN7: REG_RDATA <= drain7_reg;
          `CSOC_ADDR_DRAIN8: REG_RDATA <= drain8_reg;
          `CSOC_ADDR_OFSDIV: REG_RDATA <= ofsdiv_reg;
          default:           REG_RDATA <= 16'h0000;
        endcase
      end
    end
  end

  // -------------------------------------------------------------------
  // Compensation clock divider
  // -------------------------------------------------------------------
  // The divider runs at divide-by (value+1). Software is trusted to keep
  // the rate under the analog step limit; a too small value simply makes
  // the run end early with a poorer result.
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      div_cnt_reg <= 16'h0000;
      step_en     <= 1'b0;
    end else if (div_cnt_reg >= ofsdiv_reg) begin
      div_cnt_reg <= 16'h0000;
      step_en     <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'h0001;
      step_en     <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // Feedback synchronisers
  // -------------------------------------------------------------------
  // Comparators are asynchronous to the core clock; two stages each.
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync1_reg <= 12'h000;
      sync2_reg <= 12'h000;
      fast1_reg <= 2'h0;
      fast2_reg <= 2'h0;
    end else begin
      sync1_reg <= {DRAIN_FBK, NEG_FBK, LOW_FBK, HIGH_FBK, CUR_FBK};
      sync2_reg <= sync1_reg;
      fast1_reg <= DRAIN_FAST_FBK;
      fast2_reg <= fast1_reg;
    end
  end

  // -------------------------------------------------------------------
  // Gain, threshold and track-and-hold controls
  // -------------------------------------------------------------------
  // Commands from the microcores land directly in the analog controls.
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      GAIN_SEL      <= 12'h000;
      DAC_CODE      <= 48'h0;
      DAC_HIGH_CODE <= 16'h0000;
      NEG_CODE      <= 8'h00;
      TRACK_HOLD    <= 6'h00;
    end else begin
      for (i = 0; i < 6; i = i + 1) begin
        if (GAIN_WE && GAIN_CH == i[2:0]) begin
          GAIN_SEL[i*2 +: 2] <= GAIN_VAL;
        end
        if (DAC_WE && DAC_CH == i[2:0]) begin
          DAC_CODE[i*8 +: 8] <= DAC_VAL;
        end
      end
      if (DAC_WE && DAC_CH[2:1] == 2'h3) begin
        DAC_HIGH_CODE[DAC_CH[0]*8 +: 8] <= DAC_VAL;
      end
      if (NEG_WE) begin
        NEG_CODE[NEG_CH*4 +: 4] <= NEG_VAL;
      end
      // The hold stays closed for as long as the conversion runs.
      TRACK_HOLD <= ADC_CONV;
    end
  end

  // -------------------------------------------------------------------
  // Offset compensation
  // -------------------------------------------------------------------
  // Channels 4 and 5 compensate on their low comparators; the negative
  // amplifiers have no compensation path at all.
  csoc_ofs_seq u_ofs (
    .clk     (REF_CLK),
    .rst_n   (RESETN),
    .step_en (step_en),
    .start   (OFS_START),
    .stop    (OFS_STOP),
    .chan    (OFS_CH),
    .cmp     ({low_s, cur_s}),
    .corr    (OFS_CORR),
    .active  (OFS_ACTIVE),
    .busy    (OFS_BUSY)
  );

  // -------------------------------------------------------------------
  // Drain monitoring, regulation and boost overcurrent
  // -------------------------------------------------------------------
  // Gate turns on below the low threshold and off above the high one;
  // between them it holds, giving the hysteresis of two-point control.
  // The two synchroniser stages are the price paid in loop delay.
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      DRAIN_FAST_EN <= 2'h0;
      DRAIN_DIAG    <= 2'h0;
      RESONANCE     <= 2'h0;
      DCDC_GATE     <= 2'h0;
      BOOST_OVC     <= 2'h0;
    end else begin
      DRAIN_FAST_EN <= fast_mode;
      for (j = 0; j < 2; j = j + 1) begin
        DRAIN_DIAG[j] <= drn_s[j] & ~fast_mode[j];
        RESONANCE[j]  <= fast_s[j] & fast_mode[j];
        if (!reg_mode[j]) begin
          DCDC_GATE[j] <= 1'b0;
        end else if (high_s[j]) begin
          DCDC_GATE[j] <= 1'b0;
        end else if (!low_s[j]) begin
          DCDC_GATE[j] <= 1'b1;
        end
        BOOST_OVC[j] <= neg_s[j] & ~DCDC_GATE[j];
      end
    end
  end

endmodule

// ==== bench/csoc_properties.sv ====
`timescale 1ns/1ps
// Port-level checks for the offset control block.
module csoc_properties (
  // Clock and reset.
  input wire logic        REF_CLK,
  input wire logic        RESETN,
  // Microcore commands.
  input wire logic        GAIN_WE,
  input wire logic [2:0]  GAIN_CH,
  input wire logic [1:0]  GAIN_VAL,
  input wire logic        DAC_WE,
  input wire logic [2:0]  DAC_CH,
  input wire logic [7:0]  DAC_VAL,
  input wire logic        OFS_START,
  input wire logic        OFS_STOP,
  input wire logic [2:0]  OFS_CH,
  // Comparator feedback.
  input wire logic [1:0]  HIGH_FBK,
  input wire logic [1:0]  NEG_FBK,
  input wire logic [1:0]  DRAIN_FBK,
  // Design outputs.
  input wire logic [11:0] GAIN_SEL,
  input wire logic [47:0] DAC_CODE,
  input wire logic [35:0] OFS_CORR,
  input wire logic        OFS_BUSY,
  input wire logic [1:0]  DRAIN_DIAG,
  input wire logic [1:0]  DCDC_GATE,
  input wire logic [1:0]  BOOST_OVC
);
  // Slack over 32 steps at the reset divider, since start is not aligned.
  localparam int BUSY_MAX = 3400;
  logic [11:0] busy_cnt;  // Cycles spent in the current run.
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  // Count busy cycles so a run that never ends is caught.
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      busy_cnt <= 12'h000;
    end else begin
      busy_cnt <= OFS_BUSY ? busy_cnt + 12'h001 : 12'h000;
    end
  end
  gain_update_a: assert property (
    GAIN_WE && GAIN_CH < 3'h6 |=>
    GAIN_SEL[$past(GAIN_CH)*2 +: 2] == $past(GAIN_VAL))
    else $error("gain field not updated");
  dac_update_a: assert property (
    DAC_WE && DAC_CH < 3'h6 |=>
    DAC_CODE[$past(DAC_CH)*8 +: 8] == $past(DAC_VAL))
    else $error("threshold code not updated");
  run_start_a: assert property (
    OFS_START && !OFS_BUSY && OFS_CH < 3'h6 |=> OFS_BUSY)
    else $error("compensation did not start");
  run_bound_a: assert property (busy_cnt <= BUSY_MAX)
    else $error("compensation run too long");
  run_abort_a: assert property (
    OFS_BUSY && OFS_STOP |=> !OFS_BUSY ##1 $stable(OFS_CORR)[*4])
    else $error("stop did not abort and hold");
  idle_hold_a: assert property (
    !OFS_BUSY && !$past(OFS_BUSY) && !$past(OFS_BUSY, 2)
    |-> $stable(OFS_CORR))
    else $error("correction moved while idle");
  diag_path_a: assert property (
    DRAIN_DIAG[0] |-> $past(DRAIN_FBK[0], 3))
    else $error("diagnostic without drain feedback");
  gate_off_a: assert property (
    $past(HIGH_FBK[0], 3) |-> !DCDC_GATE[0])
    else $error("gate on above high threshold");
  boost_flag_a: assert property (
    BOOST_OVC[0] |-> $past(NEG_FBK[0], 3) && !$past(DCDC_GATE[0]))
    else $error("overcurrent flag without cause");
endmodule

// ==== bench/csoc_amp_model.sv ====
`timescale 1ns/1ps
// Amplifier and compensation comparator of each channel, with no shunt current.
module csoc_amp_model (
  // Correction words from the sequencer.
  input  wire logic [35:0] corr,
  // Comparator outputs, high above threshold.
  output logic      [5:0]  fbk
);
  // Input offsets in correction codes; signs differ to test both ways.
  localparam int OFFS [6] = '{5, 10, 0, 0, -3, 0};
  // Residual offset after the injected correction decides the output.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      fbk[i] = OFFS[i] + (corr[6*i+5] ? -int'(corr[6*i +: 5])
        : int'(corr[6*i +: 5])) > 0;
    end
  end
endmodule

// ==== bench/current_sense_offset_control_tb.sv ====
`timescale 1ns/1ps
// Ports share the design's names so the instance binds by name.
module current_sense_offset_control_tb;
  logic        REF_CLK, RESETN, REG_WR, REG_RD, plant_on;
  logic        GAIN_WE, DAC_WE, NEG_WE, OFS_START, OFS_STOP, NEG_CH;
  logic [8:0]  REG_ADDR;
  logic [15:0] REG_WDATA;
  logic [2:0]  GAIN_CH, DAC_CH, OFS_CH;
  logic [1:0]  GAIN_VAL, HIGH_FBK, low_r, NEG_FBK, DRAIN_FBK;
  logic [1:0]  DRAIN_FAST_FBK;
  logic [7:0]  DAC_VAL;
  logic [3:0]  NEG_VAL;
  logic [5:0]  ADC_CONV, mdl_fbk, TRACK_HOLD, OFS_ACTIVE;
  wire  [3:0]  CUR_FBK;
  wire  [1:0]  LOW_FBK, DRAIN_FAST_EN, DRAIN_DIAG, RESONANCE;
  wire  [1:0]  DCDC_GATE, BOOST_OVC;
  wire  [15:0] REG_RDATA, DAC_HIGH_CODE;
  wire  [11:0] GAIN_SEL;
  wire  [47:0] DAC_CODE;
  wire  [7:0]  NEG_CODE;
  wire  [35:0] OFS_CORR;
  wire         OFS_BUSY;
  int          errors, n_tests, i;
  // Rows of high, low, negative feedback, then gate and flag expected.
  logic [4:0]  row [6] = '{5'h02, 5'h0a, 5'h1d, 5'h0d, 5'h06, 5'h10};
  csoc_top dut_u (.*);
  csoc_amp_model amp_u (.corr(OFS_CORR), .fbk(mdl_fbk));
  // The plant drives the comparators only while compensation is tested.
  assign CUR_FBK = plant_on ? mdl_fbk[3:0] : 4'h0;
  assign LOW_FBK = plant_on ? mdl_fbk[5:4] : low_r;
  initial begin
    REF_CLK = 1'b0;
    forever #10 REF_CLK = ~REF_CLK;
  end
  task check(input string name, input logic [47:0] seen, want);
    n_tests++;
    if (seen !== want) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, want, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d, errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task idle(input int n);
    repeat (n) @(negedge REF_CLK);
  endtask
  task wr(input logic [8:0] a, input logic [15:0] d);
    @(negedge REF_CLK);
    {REG_WR, REG_ADDR, REG_WDATA} = {1'b1, a, d};
    @(negedge REF_CLK);
    REG_WR = 1'b0;
  endtask
  task rd(input logic [8:0] a, input logic [15:0] want);
    @(negedge REF_CLK);
    {REG_RD, REG_ADDR} = {1'b1, a};
    @(negedge REF_CLK);
    REG_RD = 1'b0;
    check("REG_RDATA", REG_RDATA, want);
  endtask
  // One-cycle command pulse: gain, threshold, negative, start, stop.
  task cmd(input int k, input logic [2:0] c, input logic [7:0] v);
    @(negedge REF_CLK);
    {GAIN_CH, DAC_CH, OFS_CH, NEG_CH} = {c, c, c, c[0]};
    {GAIN_VAL, DAC_VAL, NEG_VAL} = {v[1:0], v, v[3:0]};
    {GAIN_WE, DAC_WE, NEG_WE, OFS_START, OFS_STOP} = 5'h10 >> k;
    @(negedge REF_CLK);
    {GAIN_WE, DAC_WE, NEG_WE, OFS_START, OFS_STOP} = 5'h00;
  endtask
  task wait_idle;
    for (int w = 0; w < 3400 && OFS_BUSY !== 1'b0; w++) idle(1);
    idle(2);
    check("OFS_BUSY", OFS_BUSY, 1'b0);
  endtask
  initial begin
    {REG_WR, REG_RD, REG_ADDR, REG_WDATA, GAIN_WE, DAC_WE, NEG_WE} = '0;
    {OFS_START, OFS_STOP, NEG_CH, GAIN_CH, DAC_CH, OFS_CH} = '0;
    {GAIN_VAL, DAC_VAL, NEG_VAL, ADC_CONV, plant_on} = '0;
    {HIGH_FBK, low_r, NEG_FBK, DRAIN_FBK, DRAIN_FAST_FBK} = '0;
    {errors, n_tests, RESETN} = '0;
    idle(2);
    RESETN = 1'b1;
    rd(9'h1a4, 16'h0063);
    wr(9'h1a4, 16'h00c7);
    rd(9'h1a4, 16'h00c7);
    wr(9'h1a4, 16'h0063);
    rd(9'h182, 16'h0000);
    wr(9'h100, 16'hffff);
    rd(9'h100, 16'h0000);
    wr(9'h183, 16'h0003);
    rd(9'h183, 16'h0003);
    wr(9'h182, 16'h0003);
    {DRAIN_FBK, DRAIN_FAST_FBK} = 4'hf;
    idle(5);
    check("DRAIN_FAST_EN", DRAIN_FAST_EN, 2'h3);
    check("RESONANCE", {RESONANCE, DRAIN_DIAG}, 4'hc);
    wr(9'h182, 16'h0002);
    wr(9'h183, 16'h0002);
    idle(5);
    check("DRAIN_DIAG", {RESONANCE, DRAIN_DIAG}, 4'h3);
    {DRAIN_FBK, DRAIN_FAST_FBK} = 4'h0;
    for (i = 0; i < 6; i++) begin
      HIGH_FBK = {2{row[i][4]}};
      low_r = {2{row[i][3]}};
      NEG_FBK = {2{row[i][2]}};
      idle(6);
      check("DCDC_GATE", DCDC_GATE, {2{row[i][1]}});
      check("BOOST_OVC", BOOST_OVC, {2{row[i][0]}});
    end
    for (i = 0; i < 6; i++) begin
      cmd(0, i[2:0], {6'h00, i[1:0]});
      check("GAIN_SEL", GAIN_SEL[2*i +: 2], i[1:0]);
      cmd(1, i[2:0], 8'h0a + i[7:0]);
      check("DAC_CODE", DAC_CODE[8*i +: 8], 8'h0a + i[7:0]);
    end
    cmd(0, 3'h6, 8'h01);
    check("GAIN_SEL", GAIN_SEL, 12'h4e4);
    cmd(1, 3'h7, 8'h80);
    check("DAC_HIGH_CODE", DAC_HIGH_CODE, 16'h8000);
    cmd(2, 3'h1, 8'h0f);
    check("NEG_CODE", NEG_CODE, 8'hf0);
    ADC_CONV = 6'h2a;
    idle(2);
    check("TRACK_HOLD", TRACK_HOLD, 6'h2a);
    plant_on = 1'b1;
    cmd(3, 3'h0, 8'h00);
    check("OFS_BUSY", OFS_BUSY, 1'b1);
    idle(1);
    check("OFS_ACTIVE", OFS_ACTIVE, 6'h01);
    wait_idle;
    check("OFS_CORR", {OFS_BUSY, OFS_CORR[5:0]}, 7'h25);
    check("OFS_ACTIVE", OFS_ACTIVE, 6'h00);
    cmd(3, 3'h1, 8'h00);
    for (i = 0; i < 2000 && OFS_CORR[11:6] !== 6'h23; i++) idle(1);
    cmd(4, 3'h1, 8'h00);
    idle(250);
    check("OFS_CORR", {OFS_BUSY, OFS_CORR[11:6]}, 7'h23);
    cmd(3, 3'h1, 8'h00);
    for (i = 0; i < 300 && OFS_CORR[11:6] === 6'h23; i++) idle(1);
    check("OFS_CORR", OFS_CORR[11:6], 6'h24);
    wait_idle;
    check("OFS_CORR", {OFS_BUSY, OFS_CORR[11:6]}, 7'h2a);
    cmd(3, 3'h4, 8'h00);
    idle(1);
    check("OFS_ACTIVE", OFS_ACTIVE, 6'h10);
    wait_idle;
    check("OFS_CORR", {OFS_CORR[29:24], OFS_CORR[5:0]}, 12'h125);
    end_sim;
  end
  // Watchdog: the whole sequence needs well under 20000 cycles.
  initial begin
    #400000;
    errors++;
    end_sim;
  end
endmodule
bind csoc_top csoc_properties chk_u (.*);
